//--- hw/mstore_pkg.sv
// Package: constants for the mapped-register store and product-subtract unit
package mstore_pkg;
    localparam int DATA_W = 16;
    localparam int ACC_W = 32;
    localparam int CNT_W = 16;
    // Opcode of the product-subtract instruction
    localparam logic [15:0] OP_SUB_PRODUCT = 16'hBE05;
    // Base subtract cycle count and program-counter steps
    localparam logic [CNT_W-1:0] SUB_BASE_CYC = 16'h0001;
    localparam logic [CNT_W-1:0] PC_STEP_SUB = 16'h0001;
    localparam logic [CNT_W-1:0] PC_STEP_STORE = 16'h0002;
    // Register file for software reach (chosen offsets)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ACC_LO = 4'h1;
    localparam logic [3:0] REG_ACC_HI = 4'h2;
    localparam logic [3:0] REG_PROD_LO = 4'h3;
    localparam logic [3:0] REG_PROD_HI = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_CYCLES = 4'h6;
    localparam logic [3:0] REG_PC = 4'h7;
    // Control field positions
    localparam int CTRL_SHIFT_LSB = 0;
    localparam int CTRL_SAT_BIT = 2;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
    // Status field positions
    localparam int ST_CARRY_BIT = 0;
    localparam int ST_OVF_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    // Destination kinds
    typedef enum logic [1:0] {DST_DUAL, DST_SINGLE, DST_EXT} dst_kind_e;
endpackage : mstore_pkg

//--- hw/store_cycle_calc.sv
// Cycle-count calculator for the mapped-register store
`timescale 1ns/1ps
`default_nettype none
module store_cycle_calc #(
    parameter int CNT_W = 16
) (
    // Operation description
    input wire logic [1:0] dst_kind_in,
    input wire logic src_is_port_in,
    input wire logic src_is_periph_in,
    input wire logic same_block_in,
    input wire logic code_ext_in,
    input wire logic repeated_in,
    input wire logic [CNT_W-1:0] words_in,
    // Wait states
    input wire logic [7:0] dst_wait_in,
    input wire logic [7:0] io_wait_in,
    input wire logic [7:0] prog_wait_in,
    // Result
    output logic [CNT_W-1:0] cycles_out
);
    logic [CNT_W-1:0] n;
    logic [CNT_W-1:0] per;
    logic [CNT_W-1:0] base;
    logic [CNT_W-1:0] extra;
    logic dext;
    logic sconf;
    always_comb begin
        n = repeated_in ? words_in : 16'h0001;
        dext = (dst_kind_in == 2'(mstore_pkg::DST_EXT));
        sconf = (dst_kind_in == 2'(mstore_pkg::DST_SINGLE)) && same_block_in;
        extra = '0;
        per = '0;
        if (!repeated_in) begin
            base = dext ? 16'h0003 + CNT_W'(dst_wait_in) : 16'h0002;
            if (src_is_port_in) begin
                base = base + 16'h0001 + CNT_W'(io_wait_in);
            end
            if (sconf) begin
                base = base + 16'h0001;
            end
            if (src_is_periph_in && !src_is_port_in) begin
                base = base + 16'h0001;
            end
        end else begin
            if (src_is_port_in && dext) begin
                per = 16'h0005 + CNT_W'(dst_wait_in) + CNT_W'(io_wait_in);
                extra = 16'hFFFE;
            end else if (src_is_port_in) begin
                per = 16'h0002 + CNT_W'(io_wait_in);
            end else if (dext) begin
                per = 16'h0003 + CNT_W'(dst_wait_in);
            end else begin
                per = 16'h0002;
            end
            if (src_is_periph_in && !src_is_port_in) begin
                per = per + 16'h0001;
            end
            base = CNT_W'(per * n) + extra;
            if (sconf) begin
                base = base + 16'h0002;
            end
        end
        if (code_ext_in) begin
            base = base + CNT_W'({prog_wait_in, 1'b0});
        end
        cycles_out = base;
    end
endmodule : store_cycle_calc
`default_nettype wire

//--- hw/mstore_unit.sv
// Execution unit for mapped-register store and product subtract
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mstore_unit #(
    parameter int CNT_W = mstore_pkg::CNT_W
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // Instruction issue
    input wire logic issue_store_in,
    input wire logic issue_sub_in,
    input wire logic repeated_in,
    input wire logic [CNT_W-1:0] words_in,
    input wire logic [1:0] dst_kind_in,
    input wire logic src_is_port_in,
    input wire logic src_is_periph_in,
    input wire logic same_block_in,
    input wire logic code_ext_in,
    input wire logic [7:0] dst_wait_in,
    input wire logic [7:0] io_wait_in,
    input wire logic [7:0] prog_wait_in,
    // Register port
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    // Status
    output logic busy_out,
    output logic done_out
);
    // ==========================================================
    // Cycle computation
    logic [CNT_W-1:0] store_cyc;
    store_cycle_calc #(.CNT_W(CNT_W)) u_calc (
        .dst_kind_in(dst_kind_in),
        .src_is_port_in(src_is_port_in),
        .src_is_periph_in(src_is_periph_in),
        .same_block_in(same_block_in),
        .code_ext_in(code_ext_in),
        .repeated_in(repeated_in),
        .words_in(words_in),
        .dst_wait_in(dst_wait_in),
        .io_wait_in(io_wait_in),
        .prog_wait_in(prog_wait_in),
        .cycles_out(store_cyc)
    );

    // ==========================================================
    // State
    typedef enum logic {ST_IDLE, ST_RUN} state_e;
    state_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] last_q, last_d;
    logic [15:0] pc_q, pc_d;
    logic [31:0] acc_q, acc_d;
    logic [31:0] prod_q, prod_d;
    logic [15:0] ctrl_q, ctrl_d;
    logic carry_q, carry_d;
    logic ovf_q, ovf_d;
    logic done_q, done_d;
    logic [15:0] rdata_q, rdata_d;

    function automatic logic [31:0] shift_prod(input logic [31:0] p, input logic [1:0] m);
        case (m)
            2'd1: shift_prod = {p[30:0], 1'b0};
            2'd2: shift_prod = {p[27:0], 4'h0};
            2'd3: shift_prod = {{6{p[31]}}, p[31:6]};
            default: shift_prod = p;
        endcase
    endfunction : shift_prod

    logic [31:0] sp;
    logic [32:0] diff;
    logic sub_ovf;
    logic ovf_set;
    logic [CNT_W-1:0] sub_cyc;

    always_comb begin
        sp = shift_prod(prod_q, ctrl_q[mstore_pkg::CTRL_SHIFT_LSB +: 2]);
        diff = {1'b0, acc_q} - {1'b0, sp};
        sub_ovf = (acc_q[31] != sp[31]) && (diff[31] != acc_q[31]);
        sub_cyc = (repeated_in ? words_in : mstore_pkg::SUB_BASE_CYC)
            + (code_ext_in ? CNT_W'(prog_wait_in) : '0);
        state_d = state_q;
        cnt_d = cnt_q;
        last_d = last_q;
        pc_d = pc_q;
        acc_d = acc_q;
        prod_d = prod_q;
        ctrl_d = ctrl_q;
        carry_d = carry_q;
        ovf_d = ovf_q;
        ovf_set = 1'b0;
        done_d = 1'b0;
        rdata_d = 16'h0000;
        case (state_q)
            ST_IDLE: begin
                if (issue_store_in) begin
                    state_d = ST_RUN;
                    cnt_d = store_cyc;
                    last_d = store_cyc;
                    pc_d = pc_q + mstore_pkg::PC_STEP_STORE;
                end else if (issue_sub_in) begin
                    state_d = ST_RUN;
                    cnt_d = sub_cyc;
                    last_d = sub_cyc;
                    pc_d = pc_q + mstore_pkg::PC_STEP_SUB;
                    carry_d = ~diff[32];
                    if (sub_ovf) begin
                        ovf_d = 1'b1;
                        ovf_set = 1'b1;
                        if (ctrl_q[mstore_pkg::CTRL_SAT_BIT]) begin
                            acc_d = acc_q[31] ? 32'h8000_0000 : 32'h7FFF_FFFF;
                        end else begin
                            acc_d = diff[31:0];
                        end
                    end else begin
                        acc_d = diff[31:0];
                    end
                end
            end
            ST_RUN: begin
                cnt_d = cnt_q - 16'h0001;
                if (cnt_q <= 16'h0001) begin
                    state_d = ST_IDLE;
                    done_d = 1'b1;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // Register writes apply in every state, busy or not; accumulator and PC writes override the subtract result
        if (wr_in) begin
            if (addr_in == mstore_pkg::REG_CTRL) begin
                ctrl_d = wdata_in;
            end else if (addr_in == mstore_pkg::REG_ACC_LO) begin
                acc_d[15:0] = wdata_in;
            end else if (addr_in == mstore_pkg::REG_ACC_HI) begin
                acc_d[31:16] = wdata_in;
            end else if (addr_in == mstore_pkg::REG_PROD_LO) begin
                prod_d[15:0] = wdata_in;
            end else if (addr_in == mstore_pkg::REG_PROD_HI) begin
                prod_d[31:16] = wdata_in;
            end else if (addr_in == mstore_pkg::REG_STATUS) begin
                // Hardware set wins over a software clear
                ovf_d = (ovf_q & wdata_in[mstore_pkg::ST_OVF_BIT]) | ovf_set;
            end else if (addr_in == mstore_pkg::REG_PC) begin
                pc_d = wdata_in;
            end
        end
        if (rd_in) begin
            if (addr_in == mstore_pkg::REG_CTRL) begin
                rdata_d = ctrl_q;
            end else if (addr_in == mstore_pkg::REG_ACC_LO) begin
                rdata_d = acc_q[15:0];
            end else if (addr_in == mstore_pkg::REG_ACC_HI) begin
                rdata_d = acc_q[31:16];
            end else if (addr_in == mstore_pkg::REG_PROD_LO) begin
                rdata_d = prod_q[15:0];
            end else if (addr_in == mstore_pkg::REG_PROD_HI) begin
                rdata_d = prod_q[31:16];
            end else if (addr_in == mstore_pkg::REG_STATUS) begin
                rdata_d = {13'h0000, state_q == ST_RUN, ovf_q, carry_q};
            end else if (addr_in == mstore_pkg::REG_CYCLES) begin
                rdata_d = 16'(last_q);
            end else if (addr_in == mstore_pkg::REG_PC) begin
                rdata_d = pc_q;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            last_q <= '0;
            pc_q <= 16'h0000;
            acc_q <= 32'h0000_0000;
            prod_q <= 32'h0000_0000;
            ctrl_q <= mstore_pkg::CTRL_RESET;
            carry_q <= 1'b0;
            ovf_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else if (clk_en_in) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            last_q <= last_d;
            pc_q <= pc_d;
            acc_q <= acc_d;
            prod_q <= prod_d;
            ctrl_q <= ctrl_d;
            carry_q <= carry_d;
            ovf_q <= ovf_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_out = rdata_q;
    assign busy_out = (state_q == ST_RUN);
    assign done_out = done_q;
endmodule : mstore_unit
`default_nettype wire

//--- test/wait_mem_model.sv
// Wait-state source standing in for program, data and I/O memory
`timescale 1ns/1ps
`default_nettype none
module wait_mem_model (
    // Access kind and programmed waits
    input wire logic [1:0] kind_in,
    input wire logic port_in, code_ext_in,
    input wire logic [7:0] d_in, io_in, p_in,
    // Waits seen by the core
    output logic [7:0] dst_wait_out, io_wait_out, prog_wait_out
);
    // On-chip memory never stretches an access
    assign dst_wait_out = (kind_in == 2'h2) ? d_in : 8'h00;
    assign io_wait_out = port_in ? io_in : 8'h00;
    assign prog_wait_out = code_ext_in ? p_in : 8'h00;
endmodule : wait_mem_model
`default_nettype wire

//--- test/mstore_unit_properties.sv
// Port-level checks for the store and subtract unit
`timescale 1ns/1ps
`default_nettype none
module mstore_unit_properties (
    input wire logic clock_in, rst_n_in, clk_en_in, issue_store_in, issue_sub_in,
    input wire logic repeated_in, src_is_port_in, src_is_periph_in, same_block_in,
    input wire logic code_ext_in, busy_out, done_out,
    input wire logic [1:0] dst_kind_in,
    input wire logic [7:0] prog_wait_in
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // Plain single issues accepted while idle
    wire logic go = !busy_out && clk_en_in && !repeated_in && !src_is_port_in;
    wire logic st = go && issue_store_in && !code_ext_in && dst_kind_in != 2'h2;
    wire logic st0 = st && !src_is_periph_in;
    wire logic sr = st0 && same_block_in && dst_kind_in == 2'h1;
    wire logic sb = go && issue_sub_in && !issue_store_in;
    wire logic sx = sb && code_ext_in && prog_wait_in == 8'h01;
    a_done_fall: assert property ($fell(busy_out) |-> done_out)
        else $error("no done at end");
    a_done_pulse: assert property (done_out |-> (!busy_out && $past(busy_out)) ##1 !done_out)
        else $error("bad done pulse");
    a_store_min: assert property (issue_store_in && !busy_out && clk_en_in |=> busy_out [*2])
        else $error("store too short");
    a_store_plain: assert property (st0 && !same_block_in |=> busy_out [*2] ##1 !busy_out)
        else $error("plain store length");
    a_store_same: assert property (sr |=> busy_out [*3] ##1 !busy_out)
        else $error("same block store length");
    a_store_periph: assert property (st && src_is_periph_in && !same_block_in |=> busy_out [*3] ##1 !busy_out)
        else $error("peripheral store length");
    a_sub_one: assert property (sb && !code_ext_in |=> busy_out ##1 (!busy_out && done_out))
        else $error("subtract length");
    a_sub_fetch: assert property (sx |=> busy_out [*2] ##1 !busy_out)
        else $error("external subtract length");
endmodule : mstore_unit_properties
bind mstore_unit mstore_unit_properties i_mstore_unit_properties (.clock_in, .rst_n_in,
    .clk_en_in, .issue_store_in, .issue_sub_in, .repeated_in, .src_is_port_in,
    .src_is_periph_in, .same_block_in, .code_ext_in, .busy_out, .done_out, .dst_kind_in,
    .prog_wait_in);
`default_nettype wire

//--- test/testbench.sv
// Directed bench for the mapped-register store and product subtract unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock_in = 1'b0, rst_n_in = 1'b0, is_st = 1'b0, is_sub = 1'b0, rep = 1'b0;
    logic port = 1'b0, peri = 1'b0, same = 1'b0, cext = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
    logic ce = 1'b1;
    logic [15:0] n = 16'h0001, wdata = 16'h0000;
    logic [1:0] kind = 2'h0;
    logic [3:0] addr = 4'h0;
    logic [7:0] kd = 8'h00, ki = 8'h00, kp = 8'h00;
    wire logic [7:0] dw, iw, pw;
    wire logic [15:0] rdata_out;
    wire logic busy_out, done_out;
    int n_errors = 0, n_tests = 0;
    always #50 clock_in = ~clock_in;
    wait_mem_model i_wait_mem_model (.kind_in(kind), .port_in(port), .code_ext_in(cext),
        .d_in(kd), .io_in(ki), .p_in(kp), .dst_wait_out(dw), .io_wait_out(iw), .prog_wait_out(pw));
    mstore_unit i_mstore_unit (.clock_in, .rst_n_in, .clk_en_in(ce), .issue_store_in(is_st),
        .issue_sub_in(is_sub), .repeated_in(rep), .words_in(n), .dst_kind_in(kind),
        .src_is_port_in(port), .src_is_periph_in(peri), .same_block_in(same),
        .code_ext_in(cext), .dst_wait_in(dw), .io_wait_in(iw), .prog_wait_in(pw),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out,
        .busy_out, .done_out);
    task automatic cmp(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_in);
        {addr, wdata, wr_s} <= {a, d, 1'b1};
        @(posedge clock_in);
        wr_s <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock_in);
        {addr, rd_s} <= {a, 1'b1};
        @(posedge clock_in);
        rd_s <= 1'b0;
        #1;
        d = rdata_out;
    endtask : rd
    // Flags f are port, peripheral, same block, external code; e is the busy length
    task automatic op(input logic s, r, input logic [15:0] w, input logic [1:0] k,
        input logic [3:0] f, input logic [7:0] d, io, p, input logic [31:0] e);
        int c = 0;
        @(posedge clock_in);
        {rep, n, kind, port, peri, same, cext, kd, ki, kp} <= {r, w, k, f, d, io, p};
        is_sub <= s;
        is_st <= !s;
        @(posedge clock_in);
        {is_st, is_sub} <= 2'b00;
        #1;
        while (busy_out === 1'b1 && c < 400) begin
            c++;
            @(posedge clock_in);
            #1;
        end
        cmp(32'(c), e);
        cmp({31'h0000_0000, done_out}, 32'h0000_0001);
    endtask : op
    task automatic sc(input logic [15:0] ctl, input logic [31:0] a, p, e, input logic [15:0] s);
        logic [15:0] lo, hi;
        wr(mstore_pkg::REG_CTRL, ctl);
        wr(mstore_pkg::REG_ACC_LO, a[15:0]);
        wr(mstore_pkg::REG_ACC_HI, a[31:16]);
        wr(mstore_pkg::REG_PROD_LO, p[15:0]);
        wr(mstore_pkg::REG_PROD_HI, p[31:16]);
        wr(mstore_pkg::REG_STATUS, 16'h0000);
        op(1, 0, 1, 0, 4'h0, 0, 0, 0, 1);
        rd(mstore_pkg::REG_ACC_LO, lo);
        rd(mstore_pkg::REG_ACC_HI, hi);
        cmp({hi, lo}, e);
        rd(mstore_pkg::REG_STATUS, lo);
        cmp(lo, s);
    endtask : sc
    task automatic stop_test();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    // Tests need about 260 cycles; a hang is cut well beyond that
    initial begin
        #(1_000_000);
        n_errors++;
        stop_test();
    end
    initial begin
        logic [15:0] v, pc;
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        rd(mstore_pkg::REG_STATUS, v);
        cmp(v, 16'h0000);
        rd(4'hF, v);
        cmp(v, 16'h0000);
        op(0, 0, 1, 0, 4'h0, 0, 0, 0, 2);
        op(0, 0, 1, 2, 4'h0, 3, 0, 0, 6);
        op(0, 0, 1, 0, 4'h8, 0, 2, 0, 5);
        op(0, 0, 1, 1, 4'h2, 0, 0, 0, 3);
        op(0, 1, 4, 0, 4'h0, 0, 0, 0, 8);
        op(0, 1, 3, 2, 4'h0, 1, 0, 0, 12);
        op(0, 1, 3, 0, 4'h8, 0, 2, 0, 12);
        op(0, 1, 4, 1, 4'h2, 0, 0, 0, 10);
        op(0, 0, 1, 0, 4'h4, 0, 0, 0, 3);
        op(0, 1, 3, 0, 4'h4, 0, 0, 0, 9);
        op(0, 0, 1, 0, 4'h1, 0, 0, 2, 6);
        rd(mstore_pkg::REG_CYCLES, v);
        cmp(v, 16'h0006);
        // Enable low for three cycles mid-run: count freezes, busy shows in status
        fork
            op(0, 1, 2, 0, 4'h0, 0, 0, 0, 7);
            begin
                repeat (3) @(posedge clock_in);
                ce <= 1'b0;
                repeat (3) @(posedge clock_in);
                ce <= 1'b1;
                rd(mstore_pkg::REG_STATUS, v);
                cmp(v, 16'h0004);
            end
        join
        $display("store timing test done");
        sc(16'h0000, 32'h7000_0000, 32'h1000_0000, 32'h6000_0000, 16'h0001);
        sc(16'h0001, 32'h7000_0000, 32'h1000_0000, 32'h5000_0000, 16'h0001);
        sc(16'h0003, 32'h7000_0000, 32'h1000_0000, 32'h6FC0_0000, 16'h0001);
        sc(16'h0000, 32'h0000_0000, 32'h0000_0001, 32'hFFFF_FFFF, 16'h0000);
        sc(16'h0004, 32'h8000_0000, 32'h0000_0001, 32'h8000_0000, 16'h0003);
        sc(16'h0000, 32'h8000_0000, 32'h0000_0001, 32'h7FFF_FFFF, 16'h0003);
        rd(mstore_pkg::REG_PC, pc);
        op(1, 0, 1, 0, 4'h0, 0, 0, 0, 1);
        rd(mstore_pkg::REG_PC, v);
        cmp(v, pc + 16'h0001);
        op(1, 0, 1, 0, 4'h1, 0, 0, 1, 2);
        op(1, 1, 3, 0, 4'h0, 0, 0, 0, 3);
        $display("subtract test done");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
